//--- rtl/irq_gate_pkg.sv
`default_nettype none

package irq_gate_pkg;

    // ------------------------------------------------------------
    // Register offsets inside the board window
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_FIRST_COUNTER = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_SECOND_COUNTER = 12'h011;
    localparam logic [ADDR_W-1:0] OFS_COUNTER_CONFIG = 12'h013;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL_ONE = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL_TWO = 12'h015;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 12'h016;

    // ------------------------------------------------------------
    // Field layout of irq_control_one
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int BIT_SOURCE_SELECT = 0;
    localparam int BIT_COUNTER_IRQ_ENABLE = 1;
    localparam int BIT_GLOBAL_IRQ_ENABLE = 2;
    localparam logic [DATA_W-1:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] CTRL_TWO_RESET = 8'h00;

    // ------------------------------------------------------------
    // Timing counts, in clock cycles
    // ------------------------------------------------------------
    localparam int WRITE_TO_STROBE_CYC = 1;
    localparam int EDGE_TO_IRQ_CYC = 2;
    localparam int CLEAR_TO_IRQ_LOW_CYC = 2;

endpackage

`default_nettype wire

//--- rtl/source_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

// Rising-edge detector for a counter output that is already synchronous.
module source_edge_detect
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Level in, pulse out
    input wire logic level,
    output logic rise
);

    logic prev_q;

    always_ff @(posedge clk)
    begin
        if (srst)
            prev_q <= 1'b0;
        else
            prev_q <= level;
    end

    assign rise = level & ~prev_q;

endmodule

`default_nettype wire

//--- rtl/pending_latch.sv
`timescale 1ns/1ps
`default_nettype none

// Sticky request flag. A set in the same cycle as a clear wins, so an
// edge arriving while software acknowledges the previous one is kept.
module pending_latch
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control
    input wire logic set,
    input wire logic clr,
    // State
    output logic pend_q
);

    logic pend_d;

    assign pend_d = set | (pend_q & ~clr);

    always_ff @(posedge clk)
    begin
        if (srst)
            pend_q <= 1'b0;
        else
            pend_q <= pend_d;
    end

endmodule

`default_nettype wire

//--- rtl/counter_interrupt_gate.sv
// Functional notes
// - Global enable bit 2 set lets the board raise its interrupt.
// - Global enable clear keeps the interrupt low, whatever control two holds.
// - Counter enable bit 1 set lets the selected counter raise a request.
// - Counter enable clear gives counter outputs no effect on the request.
// - Source select bit 0 set: counter 1 is source, counter 0 prescales it.
// - Source select clear: counter 0 output is the interrupt source.
// - Without counters, bits 1 and 0 are reserved; only global enable works.
// - A byte write to offset 0x16 clears the request unless a source edge sets it in the same cycle; data ignored.
// - Control one decodes at 0x14, control two at 0x15.
// - Counter registers decode at 0x10 and 0x11, counter configuration at 0x13.
`timescale 1ns/1ps
`default_nettype none

module counter_interrupt_gate
    import irq_gate_pkg::*;
#(
    parameter bit HAS_COUNTERS = 1'b1
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Host byte write port
    input wire logic host_wr,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic [DATA_W-1:0] host_wdata,
    // Counter outputs
    input wire logic counter0_out,
    input wire logic counter1_out,
    // Counter block write strobes and data
    output logic first_counter_wr_q,
    output logic second_counter_wr_q,
    output logic counter_config_wr_q,
    output logic [DATA_W-1:0] counter_wdata_q,
    output logic prescale_chain_q,
    // Interrupt control two contents for the port logic
    output logic [DATA_W-1:0] irq_control_two_q,
    // Interrupt state
    output logic irq_pending_q,
    output logic host_irq_q
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic hit_ctrl_one;
    logic hit_ctrl_two;
    logic hit_clear;
    logic hit_first_counter;
    logic hit_second_counter;
    logic hit_counter_config;

    assign hit_ctrl_one = host_wr && (host_addr == OFS_IRQ_CONTROL_ONE);
    assign hit_ctrl_two = host_wr && (host_addr == OFS_IRQ_CONTROL_TWO);
    assign hit_clear = host_wr && (host_addr == OFS_IRQ_CLEAR);
    assign hit_first_counter = host_wr && (host_addr == OFS_FIRST_COUNTER);
    assign hit_second_counter = host_wr && (host_addr == OFS_SECOND_COUNTER);
    assign hit_counter_config = host_wr && (host_addr == OFS_COUNTER_CONFIG);

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Only the live bits of control one are stored; its reserved bits are dropped at the
    // write so no stale value can ever steer the gate.
    logic [DATA_W-1:0] live_mask;
    logic [DATA_W-1:0] ctrl_one_q;
    logic [DATA_W-1:0] ctrl_one_d;
    logic [DATA_W-1:0] ctrl_two_d;

    assign live_mask = HAS_COUNTERS ? 8'h07 : 8'h04;
    assign ctrl_one_d = hit_ctrl_one ? (host_wdata & live_mask) : ctrl_one_q;
    assign ctrl_two_d = hit_ctrl_two ? host_wdata : irq_control_two_q;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_one_q <= CTRL_ONE_RESET;
            irq_control_two_q <= CTRL_TWO_RESET;
        end
        else
        begin
            ctrl_one_q <= ctrl_one_d;
            irq_control_two_q <= ctrl_two_d;
        end
    end

    logic global_irq_enable;
    logic counter_irq_enable;
    logic counter_source_select;

    assign global_irq_enable = ctrl_one_q[BIT_GLOBAL_IRQ_ENABLE];
    assign counter_irq_enable = ctrl_one_q[BIT_COUNTER_IRQ_ENABLE];
    assign counter_source_select = ctrl_one_q[BIT_SOURCE_SELECT];

    // ------------------------------------------------------------
    // Counter block strobes
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            first_counter_wr_q <= 1'b0;
            second_counter_wr_q <= 1'b0;
            counter_config_wr_q <= 1'b0;
            counter_wdata_q <= 8'h00;
            prescale_chain_q <= 1'b0;
        end
        else
        begin
            first_counter_wr_q <= hit_first_counter;
            second_counter_wr_q <= hit_second_counter;
            counter_config_wr_q <= hit_counter_config;
            counter_wdata_q <= host_wdata;
            prescale_chain_q <= counter_source_select;
        end
    end

    // ------------------------------------------------------------
    // Source selection and request latch
    // ------------------------------------------------------------
    // Counter 1 runs off counter 0 when chained, so its output is the one
    // watched; otherwise counter 0 is watched directly.
    logic selected_src;
    logic src_rise;
    logic pend_set;
    logic irq_d;

    assign selected_src = counter_source_select ? counter1_out
        : counter0_out;

    source_edge_detect u_edge
    (
        .clk(clk),
        .srst(srst),
        .level(selected_src),
        .rise(src_rise)
    );

    assign pend_set = src_rise && counter_irq_enable && HAS_COUNTERS;

    pending_latch u_pend
    (
        .clk(clk),
        .srst(srst),
        .set(pend_set),
        .clr(hit_clear),
        .pend_q(irq_pending_q)
    );

    // Counter enable also gates the output so a request latched earlier
    // cannot escape once software turns the counter source off.
    assign irq_d = irq_pending_q && counter_irq_enable && global_irq_enable;

    always_ff @(posedge clk)
    begin
        if (srst)
            host_irq_q <= 1'b0;
        else
            host_irq_q <= irq_d;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // An armed edge must reach the host, but only while control one is left
    // alone in the same cycle, since a write there changes the gate a cycle on.
    sequence s_armed_edge;
        src_rise && counter_irq_enable && global_irq_enable && !hit_ctrl_one;
    endsequence

    sequence s_pend_then_irq;
        irq_pending_q ##1 host_irq_q;
    endsequence

    sequence s_clear_alone;
        hit_clear && !pend_set;
    endsequence

    a_global_gate_low: assert property (@(posedge clk) disable iff (srst)
        !global_irq_enable |=> !host_irq_q)
        else $error("Interrupt raised while global enable was clear.");

    a_counter_gate_low: assert property (@(posedge clk) disable iff (srst)
        !counter_irq_enable |=> !host_irq_q)
        else $error("Interrupt raised while counter enable was clear.");

    a_edge_to_irq: assert property (@(posedge clk) disable iff (srst)
        s_armed_edge |=> s_pend_then_irq)
        else $error("Enabled source edge did not raise the interrupt in two cycles.");

    a_clear_drops_irq: assert property (@(posedge clk) disable iff (srst)
        s_clear_alone |-> ##CLEAR_TO_IRQ_LOW_CYC !host_irq_q)
        else $error("Clear write did not drop the interrupt.");

    a_set_beats_clear: assert property (@(posedge clk) disable iff (srst)
        pend_set && hit_clear |=> irq_pending_q)
        else $error("Source edge lost when it met a clear write.");

    a_pending_holds: assert property (@(posedge clk) disable iff (srst)
        irq_pending_q && !hit_clear |=> irq_pending_q)
        else $error("Pending request dropped without a clear write.");

    a_source_zero: assert property (@(posedge clk) disable iff (srst)
        !counter_source_select && $stable(counter_source_select) && $rose(counter0_out)
        && !counter1_out && counter_irq_enable && HAS_COUNTERS |=> irq_pending_q)
        else $error("Counter 0 edge not latched with source select clear.");

    a_source_one: assert property (@(posedge clk) disable iff (srst)
        counter_source_select && $stable(counter_source_select) && $rose(counter0_out)
        && $stable(counter1_out) && !irq_pending_q |=> !irq_pending_q)
        else $error("Counter 0 edge latched while counter 1 was selected.");

    a_reserved_bits: assert property (@(posedge clk) disable iff (srst)
        hit_ctrl_one |=> ctrl_one_q[7:3] == 5'h00
        && (HAS_COUNTERS || ctrl_one_q[1:0] == 2'h0))
        else $error("Reserved control bits took a value.");

    a_ctrl_one_store: assert property (@(posedge clk) disable iff (srst)
        hit_ctrl_one
        |=> global_irq_enable == $past(host_wdata[BIT_GLOBAL_IRQ_ENABLE]))
        else $error("Control one write did not land at its offset.");

    a_counter_strobe: assert property (@(posedge clk) disable iff (srst)
        hit_second_counter |-> ##WRITE_TO_STROBE_CYC second_counter_wr_q
        && !first_counter_wr_q && !counter_config_wr_q)
        else $error("Counter 1 write strobe missing or misdecoded.");

    // ------------------------------------------------------------
    // Assertions on gating, clearing and decode side effects
    // ------------------------------------------------------------
    a_pend_needs_en: assert property (@(posedge clk) disable iff (srst)
        !counter_irq_enable && !irq_pending_q |=> !irq_pending_q)
        else $error("Request latched while counter enable was clear.");

    a_irq_needs_pend: assert property (@(posedge clk) disable iff (srst)
        !irq_pending_q |=> !host_irq_q)
        else $error("Interrupt raised with no pending request.");

    a_gate_open: assert property (@(posedge clk) disable iff (srst)
        irq_pending_q && counter_irq_enable && global_irq_enable |=> host_irq_q)
        else $error("Pending request with both enables set did not reach the host.");

    a_clear_ends_pend: assert property (@(posedge clk) disable iff (srst)
        s_clear_alone |=> !irq_pending_q)
        else $error("Clear write left the request pending.");

    a_clear_keeps_ctrl: assert property (@(posedge clk) disable iff (srst)
        hit_clear |=> $stable(ctrl_one_q) && $stable(irq_control_two_q))
        else $error("Clear write disturbed the control registers.");

    a_lite_no_pend: assert property (@(posedge clk) disable iff (srst)
        !HAS_COUNTERS |-> !irq_pending_q && !host_irq_q)
        else $error("Reduced variant raised a counter request.");

    a_ctrl_two_store: assert property (@(posedge clk) disable iff (srst)
        hit_ctrl_two |=> irq_control_two_q == $past(host_wdata))
        else $error("Control two write did not land at its offset.");

    a_ctrl_one_keep: assert property (@(posedge clk) disable iff (srst)
        !hit_ctrl_one |=> $stable(ctrl_one_q))
        else $error("Control one changed without a write to its offset.");

    a_first_strobe: assert property (@(posedge clk) disable iff (srst)
        hit_first_counter |=> first_counter_wr_q && !second_counter_wr_q
        && !counter_config_wr_q)
        else $error("Counter 0 write strobe missing or misdecoded.");

    a_config_strobe: assert property (@(posedge clk) disable iff (srst)
        hit_counter_config |=> counter_config_wr_q && !first_counter_wr_q
        && !second_counter_wr_q)
        else $error("Counter configuration strobe missing or misdecoded.");

    a_strobe_data: assert property (@(posedge clk) disable iff (srst)
        hit_first_counter || hit_second_counter || hit_counter_config
        |=> counter_wdata_q == $past(host_wdata))
        else $error("Counter write data not forwarded with its strobe.");

    a_idle_no_strobe: assert property (@(posedge clk) disable iff (srst)
        !host_wr |=> !first_counter_wr_q && !second_counter_wr_q && !counter_config_wr_q)
        else $error("Counter strobe raised with no host write.");

    // The chain flag is a register behind control one, so it trails the write
    // by two edges; the counter block must tolerate that short lag.
    a_prescale_follow: assert property (@(posedge clk) disable iff (srst)
        HAS_COUNTERS && hit_ctrl_one
        |-> ##2 prescale_chain_q == $past(host_wdata[BIT_SOURCE_SELECT], 2))
        else $error("Prescale chain did not follow the source select bit.");

    a_unmapped_quiet: assert property (@(posedge clk) disable iff (srst)
        host_wr && !(hit_ctrl_one || hit_ctrl_two || hit_clear || hit_first_counter
        || hit_second_counter || hit_counter_config)
        |=> $stable(ctrl_one_q) && $stable(irq_control_two_q) && !second_counter_wr_q)
        else $error("Write to an unmapped offset changed the block.");

endmodule

`default_nettype wire

//--- dv/host_model.sv
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------
// Host side byte writer
// --------------------------------------------
module host_model
    import irq_gate_pkg::*;
(
    // Clock
    input wire logic clk,
    // Byte write request
    output logic host_wr,
    output logic [ADDR_W-1:0] host_addr,
    output logic [DATA_W-1:0] host_wdata
);
    initial
    begin
        host_wr = 1'b0;
        host_addr = 12'h000;
        host_wdata = 8'h00;
    end

    // A released bus shows inverted values, so stale data never looks valid.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    begin
        @(posedge clk);
        #1;
        host_wr = 1'b1;
        host_addr = a;
        host_wdata = d;
        @(posedge clk);
        #1;
        host_wr = 1'b0;
        host_addr = ~a;
        host_wdata = ~d;
    end
    endtask

    // The global enable goes in last, so the interrupt stays low while the other bits are written.
    task automatic setup_ctrl(input logic [DATA_W-1:0] c);
    begin
        wr(OFS_IRQ_CONTROL_ONE, c & 8'hFB);
        wr(OFS_IRQ_CONTROL_ONE, c);
    end
    endtask
endmodule

`default_nettype wire

//--- dv/counter_interrupt_gate_bench.sv
`timescale 1ns/1ps
`default_nettype none

module counter_interrupt_gate_bench;
    import irq_gate_pkg::*;
    logic clk, srst, c0, c1, host_wr, s0, s1, s2, pre, pend, irq, pend_l, irq_l;
    logic [ADDR_W-1:0] host_addr;
    logic [DATA_W-1:0] host_wdata, cdata, two, d;
    logic [ADDR_W-1:0] ofs [4] = '{12'h010, 12'h011, 12'h013, 12'h012};
    int seed, bad_count, n_tests;

    // --------------------------------------------
    // Structure
    // --------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    host_model host (.clk(clk), .host_wr(host_wr), .host_addr(host_addr),
        .host_wdata(host_wdata));

    counter_interrupt_gate #(.HAS_COUNTERS(1'b1)) dut (.clk(clk), .srst(srst),
        .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
        .counter0_out(c0), .counter1_out(c1), .first_counter_wr_q(s0),
        .second_counter_wr_q(s1), .counter_config_wr_q(s2), .counter_wdata_q(cdata),
        .prescale_chain_q(pre), .irq_control_two_q(two), .irq_pending_q(pend),
        .host_irq_q(irq));

    // The reduced variant shares every input, so its request must stay low.
    counter_interrupt_gate #(.HAS_COUNTERS(1'b0)) dut_lite (.clk(clk), .srst(srst),
        .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
        .counter0_out(c0), .counter1_out(c1), .first_counter_wr_q(),
        .second_counter_wr_q(), .counter_config_wr_q(), .counter_wdata_q(),
        .prescale_chain_q(), .irq_control_two_q(), .irq_pending_q(pend_l),
        .host_irq_q(irq_l));

    // --------------------------------------------
    // Checking helpers
    // --------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    begin
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    end
    endtask

    function automatic logic [7:0] strobe_exp(input int i);
        return (i < 3) ? (8'h04 >> i) : 8'h00;
    endfunction

    function automatic logic pend_exp(input logic [7:0] c, input logic src);
        return c[1] & (src == c[0]);
    endfunction

    task automatic summarize;
    begin
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    // One source edge, then hold, then clear with arbitrary data.
    task automatic run_irq(input logic [7:0] c, input logic src);
        logic ep;
    begin
        ep = pend_exp(c, src);
        host.setup_ctrl(c);
        @(posedge clk);
        #1;
        if (src)
            c1 = 1'b1;
        else
            c0 = 1'b1;
        repeat (EDGE_TO_IRQ_CYC + 1) @(posedge clk);
        #1;
        chk("irq", {7'h00, ep & c[2]}, {7'h00, irq});
        chk("lite", 8'h00, {6'h00, pend_l, irq_l});
        c0 = 1'b0;
        c1 = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("pending", {7'h00, ep}, {7'h00, pend});
        host.wr(OFS_IRQ_CLEAR, 8'($random(seed)));
        repeat (CLEAR_TO_IRQ_LOW_CYC) @(posedge clk);
        #1;
        chk("cleared", 8'h00, {6'h00, pend, irq});
    end
    endtask

    // --------------------------------------------
    // Tests
    // --------------------------------------------
    initial
    begin
        #(50 * 5000);
        bad_count++;
        summarize;
    end

    initial
    begin
        seed = 92;
        bad_count = 0;
        n_tests = 0;
        srst = 1'b1;
        c0 = 1'b0;
        c1 = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        srst = 1'b0;
        chk("reset", 8'h00, {2'h0, s0, s1, s2, pre, pend, irq});
        chk("reset_two", CTRL_TWO_RESET, two);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            d = 8'($random(seed));
            host.wr(ofs[i], d);
            chk("strobes", strobe_exp(i), {5'h00, s0, s1, s2});
            if (i < 3)
                chk("counter_data", d, cdata);
        end
        d = 8'($random(seed));
        host.wr(OFS_IRQ_CONTROL_TWO, d);
        chk("control_two", d, two);
        for (int j = 0; j < 2; j++)
        begin
            host.wr(OFS_IRQ_CONTROL_ONE, {5'($random(seed)), 3'(j)});
            @(posedge clk);
            #1;
            chk("prescale", 8'(j), {7'h00, pre});
        end
        $display("test decode done");
        run_irq(8'h06, 1'b0);
        run_irq(8'h07, 1'b1);
        run_irq(8'h07, 1'b0);
        run_irq(8'h06, 1'b1);
        run_irq(8'h04, 1'b0);
        run_irq(8'h02, 1'b0);
        run_irq(8'hFE, 1'b0);
        run_irq(8'hFB, 1'b1);
        $display("test corner irq done");
        for (int k = 0; k < 16; k++)
            run_irq(8'($random(seed)), 1'($random(seed)));
        $display("test random irq done");
        summarize;
    end
endmodule

`default_nettype wire
